// >>> inc/lpm_pkg.sv
// constants, state encoding and state record for the low power mode sequencer
// Notes on behaviour
// R1: Light sleep stops only the core clock.
// R2: Light sleep holds execution until interrupt or reset.
// R3: Deep sleep stops oscillator; pins stay static.
// R4: Deep sleep retains processor, register, SRAM state.
// R5: Deep sleep gates RC output; RTC oscillator runs.
// R6: Deep entry kills PLL, zeroes core/USB dividers.
// R7: Deep sleep ends on reset or clockless interrupt.
// R8: Flash stays powered throughout deep sleep.
// R9: RC source: resume after 4 oscillator cycles.
// R10: Main oscillator source: resume after 4096 cycles.
// R11: Software reprograms PLL and dividers after wake.
// R12: Power-down adds RC and flash power off.
// R13: Power-down wake: 60 us RC start-up first.
// R14: Then 4 RC cycles before resuming from SRAM; code waits 4096 main cycles instead if main was the source.
// R15: Flash timer counts RC cycles, blocks flash.
// R16: Flash timer releases at 400 RC cycles.
// R17: Deep power-down entered only from RTC request.
// R18: Deep power-down powers only RTC and reset.
// R19: Deep power-down exits on reset pin or alarm.
// R20: Interrupt controller hands wake mask at entry.
// R21: Wake latch fires on masked interrupt, no polling.
// R22: Each peripheral clock gated by software control.
// R23: Each peripheral has its own clock divider.
// R24: Always-on domain keeps RTC running.
package lpm_pkg;
  localparam int unsigned CORE_MHZ = 250;
  localparam int unsigned IRC_MHZ = 4;
  localparam int unsigned NIRQ = 32;
  localparam int unsigned NPER = 4;
  localparam int unsigned PDIV_W = 4;
  localparam int unsigned CDIV_W = 8;
  localparam int unsigned UDIV_W = 4;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned FCNT_W = 9;
  // wake timing in oscillator cycles
  localparam int unsigned DS_IRC_CYC = 4;
  localparam int unsigned DS_OSC_CYC = 4096;
  localparam int unsigned PD_IRC_CYC = 4;
  // start-up times in ns, converted to cycles
  localparam int unsigned IRC_START_NS = 60000;
  localparam int unsigned IRC_START_CYC = (IRC_START_NS * CORE_MHZ + 999) / 1000;
  localparam int unsigned FLASH_START_NS = 100000;
  localparam int unsigned FLASH_CYC = (FLASH_START_NS * IRC_MHZ + 999) / 1000;
  // sleep request mode select codes
  localparam logic [1:0] MODE_LIGHT = 2'h0;
  localparam logic [1:0] MODE_DEEP = 2'h1;
  localparam logic [1:0] MODE_PDOWN = 2'h2;

  typedef enum logic [2:0] {
    ST_RUN = 3'h0,
    ST_SLEEP = 3'h1,
    ST_DSLEEP = 3'h2,
    ST_PDOWN = 3'h3,
    ST_DPD = 3'h4,
    ST_IRC_START = 3'h5,
    ST_OSC_WAIT = 3'h6
  } state_e;

  typedef struct packed {
    state_e state;
    logic [CNT_W-1:0] cnt;
    logic [FCNT_W-1:0] flash_cnt;
    logic flash_busy;
    logic src_main;
    logic core_clk_en;
    logic osc_en;
    logic irc_out_en;
    logic irc_pwr;
    logic pll_en;
    logic pll_conn;
    logic flash_pwr;
    logic flash_ok;
    logic pins_hold;
    logic retain;
    logic main_pwr;
    logic wic_capture;
    logic wic_clear;
    logic [CDIV_W-1:0] cpu_core_clock_div;
    logic [UDIV_W-1:0] usb_div;
    logic [NPER-1:0][PDIV_W-1:0] pdiv_cnt;
    logic [NPER-1:0] pclk_en;
  } lpm_s;

  localparam lpm_s LPM_RESET = '{
    state: ST_RUN, cnt: '0, flash_cnt: '0, flash_busy: 1'b0, src_main: 1'b0,
    core_clk_en: 1'b1, osc_en: 1'b0, irc_out_en: 1'b1, irc_pwr: 1'b1,
    pll_en: 1'b0, pll_conn: 1'b0, flash_pwr: 1'b1, flash_ok: 1'b1,
    pins_hold: 1'b0, retain: 1'b0, main_pwr: 1'b1, wic_capture: 1'b0,
    wic_clear: 1'b0, cpu_core_clock_div: '0, usb_div: '0, pdiv_cnt: '0, pclk_en: '0
  };

  typedef struct packed {
    logic [NIRQ-1:0] mask;
    logic armed;
    logic pend;
  } wic_s;

  localparam wic_s WIC_RESET = '{mask: '0, armed: 1'b0, pend: 1'b0};
endpackage : lpm_pkg

// >>> src/low_power_mode_sequencer.sv
// low power mode sequencer: mode entry, clock and power gating, wake timing
`timescale 1ns/1ps
module low_power_mode_sequencer #(
  parameter int unsigned IRC_START_CYC = lpm_pkg::IRC_START_CYC
) (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic sleep_req_in,
  input wire logic [1:0] mode_sel_in,
  input wire logic rtc_dpd_req_in,
  input wire logic rtc_alarm_in,
  input wire logic reset_pin_in,
  input wire logic clk_src_main_in,
  input wire logic irc_tick_in,
  input wire logic main_osc_tick_in,
  input wire logic [lpm_pkg::NIRQ-1:0] irq_in,
  input wire logic [lpm_pkg::NIRQ-1:0] irq_mask_in,
  input wire logic pll_wr_in,
  input wire logic pll_en_in,
  input wire logic pll_conn_in,
  input wire logic div_wr_in,
  input wire logic [lpm_pkg::CDIV_W-1:0] cpu_core_clock_div_in,
  input wire logic [lpm_pkg::UDIV_W-1:0] usb_div_in,
  input wire logic [lpm_pkg::NPER-1:0] periph_gate_in,
  input wire logic [lpm_pkg::NPER*lpm_pkg::PDIV_W-1:0] periph_div_in,
  output logic core_clk_en_out,
  output logic main_osc_en_out,
  output logic irc_out_en_out,
  output logic irc_pwr_en_out,
  output logic rtc_osc_en_out,
  output logic pll_en_out,
  output logic pll_connect_out,
  output logic [lpm_pkg::CDIV_W-1:0] cpu_core_clock_div_out,
  output logic [lpm_pkg::UDIV_W-1:0] usb_div_out,
  output logic flash_pwr_en_out,
  output logic flash_ready_out,
  output logic pins_hold_out,
  output logic retain_out,
  output logic main_pwr_en_out,
  output logic [2:0] mode_out,
  output logic [lpm_pkg::NPER-1:0] periph_clk_en_out
);
  lpm_pkg::lpm_s q, d;
  logic wic_wake;
  logic osc_tick;
  logic [lpm_pkg::CNT_W-1:0] osc_lim;

  ////////////////////////////////////////////////////////////////////////
  // shared entry actions of every oscillator-stopped mode (deep sleep, power-down, deep power-down)
  function automatic lpm_pkg::lpm_s enter_deep(input lpm_pkg::lpm_s s, input logic main_src);
    lpm_pkg::lpm_s r;
    r = s;
    r.core_clk_en = 1'b0;
    r.osc_en = 1'b0; // R3
    r.irc_out_en = 1'b0; // R5
    r.pll_en = 1'b0; // R6
    r.pll_conn = 1'b0; // R6
    r.cpu_core_clock_div = '0; // R6
    r.usb_div = '0; // R6
    r.pins_hold = 1'b1; // R3
    r.retain = 1'b1; // R4
    r.src_main = main_src;
    r.wic_capture = 1'b1; // R20
    r.cnt = '0;
    return r;
  endfunction : enter_deep

  function automatic logic clocks_running(input lpm_pkg::state_e s);
    return (s == lpm_pkg::ST_RUN) || (s == lpm_pkg::ST_SLEEP);
  endfunction : clocks_running

  ////////////////////////////////////////////////////////////////////////
  wake_interrupt_latch u_wake_latch (
    .core_clk_in(core_clk_in),
    .srst_in(srst_in),
    .capture_in(q.wic_capture),
    .mask_in(irq_mask_in),
    .irq_in(irq_in),
    .clear_in(q.wic_clear),
    .wake_out(wic_wake)
  );

  // outside deep power-down, which always resumes on the rc, the oscillator that was in use before entry times the resume
  assign osc_tick = q.src_main ? main_osc_tick_in : irc_tick_in;
  assign osc_lim = q.src_main ? lpm_pkg::CNT_W'(lpm_pkg::DS_OSC_CYC) // R10
                 : (q.flash_busy ? lpm_pkg::CNT_W'(lpm_pkg::PD_IRC_CYC) // R14
                 : lpm_pkg::CNT_W'(lpm_pkg::DS_IRC_CYC)); // R9

  ////////////////////////////////////////////////////////////////////////
  // next state of the whole sequencer
  always_comb begin
    d = q;
    d.wic_capture = 1'b0;
    d.wic_clear = 1'b0;

    // per-peripheral gate and divider, live while clocks run
    for (int i = 0; i < lpm_pkg::NPER; i++) begin
      if (!periph_gate_in[i] || !clocks_running(q.state)) begin
        d.pdiv_cnt[i] = '0; // R22
        d.pclk_en[i] = 1'b0; // R22
      end else if (q.pdiv_cnt[i] == periph_div_in[i*lpm_pkg::PDIV_W +: lpm_pkg::PDIV_W]) begin
        d.pdiv_cnt[i] = '0; // R23
        d.pclk_en[i] = 1'b1;
      end else begin
        d.pdiv_cnt[i] = q.pdiv_cnt[i] + 1'b1; // R23
        d.pclk_en[i] = 1'b0;
      end
    end

    // flash start-up timer runs on RC ticks regardless of core state
    if (q.flash_busy && irc_tick_in) begin
      if (q.flash_cnt == lpm_pkg::FCNT_W'(lpm_pkg::FLASH_CYC - 1)) begin
        d.flash_busy = 1'b0; // R16
        d.flash_ok = 1'b1; // R15
      end else begin
        d.flash_cnt = q.flash_cnt + 1'b1; // R15
      end
    end

    unique case (q.state)
      lpm_pkg::ST_RUN: begin
        // plls and dividers are set only by software writes and cleared on deep entry, never restored on wake
        if (pll_wr_in) begin
          d.pll_en = pll_en_in; // R11
          d.pll_conn = pll_conn_in & pll_en_in;
        end
        if (div_wr_in) begin
          d.cpu_core_clock_div = cpu_core_clock_div_in; // R11
          d.usb_div = usb_div_in;
        end
        if (rtc_dpd_req_in) begin
          d = enter_deep(d, 1'b0); // R17
          d.irc_pwr = 1'b0;
          d.flash_pwr = 1'b0;
          d.flash_ok = 1'b0;
          d.main_pwr = 1'b0; // R18
          d.state = lpm_pkg::ST_DPD;
        end else if (sleep_req_in) begin
          // a sleep request with the unused mode code is ignored
          if (mode_sel_in == lpm_pkg::MODE_LIGHT) begin
            d.core_clk_en = 1'b0; // R1
            d.state = lpm_pkg::ST_SLEEP;
          end else if (mode_sel_in == lpm_pkg::MODE_DEEP) begin
            d = enter_deep(d, clk_src_main_in); // R8
            d.state = lpm_pkg::ST_DSLEEP;
          end else if (mode_sel_in == lpm_pkg::MODE_PDOWN) begin
            d = enter_deep(d, clk_src_main_in); // R12
            d.irc_pwr = 1'b0; // R12
            d.flash_pwr = 1'b0; // R12
            d.flash_ok = 1'b0;
            d.state = lpm_pkg::ST_PDOWN;
          end
        end
      end
      lpm_pkg::ST_SLEEP: begin
        // peripherals keep running; any enabled interrupt resumes the core
        if (|(irq_in & irq_mask_in)) begin
          d.core_clk_en = 1'b1; // R2
          d.state = lpm_pkg::ST_RUN;
        end
      end
      lpm_pkg::ST_DSLEEP: begin
        // the latch still shows the last wake until the capture lands
        if (wic_wake && !q.wic_capture) begin
          d.wic_clear = 1'b1; // R7
          d.cnt = '0;
          if (q.src_main) begin
            d.osc_en = 1'b1;
          end else begin
            d.irc_out_en = 1'b1;
          end
          d.state = lpm_pkg::ST_OSC_WAIT;
        end
      end
      lpm_pkg::ST_PDOWN: begin
        if (wic_wake && !q.wic_capture) begin // R21
          d.wic_clear = 1'b1;
          d.irc_pwr = 1'b1;
          d.flash_pwr = 1'b1;
          d.cnt = '0;
          d.state = lpm_pkg::ST_IRC_START;
        end
      end
      lpm_pkg::ST_DPD: begin
        // only the reset pin and the alarm reach this always-on logic
        if (rtc_alarm_in || reset_pin_in) begin
          d.wic_clear = 1'b1; // R19
          d.main_pwr = 1'b1;
          d.irc_pwr = 1'b1;
          d.flash_pwr = 1'b1;
          d.src_main = 1'b0;
          d.cnt = '0;
          d.state = lpm_pkg::ST_IRC_START;
        end
      end
      lpm_pkg::ST_IRC_START: begin
        // no rc ticks exist yet, so the start-up is timed in core cycles
        if (q.cnt == lpm_pkg::CNT_W'(IRC_START_CYC - 1)) begin
          d.cnt = '0; // R13
          d.irc_out_en = 1'b1;
          d.flash_busy = 1'b1; // R15
          d.flash_cnt = '0;
          d.osc_en = q.src_main;
          d.state = lpm_pkg::ST_OSC_WAIT;
        end else begin
          d.cnt = q.cnt + 1'b1; // R13
        end
      end
      lpm_pkg::ST_OSC_WAIT: begin
        // code in sram may run before the flash timer ends
        if (osc_tick) begin
          if (q.cnt == osc_lim - 1'b1) begin
            d.cnt = '0;
            d.core_clk_en = 1'b1; // R9
            d.pins_hold = 1'b0;
            d.retain = 1'b0;
            d.state = lpm_pkg::ST_RUN;
          end else begin
            d.cnt = q.cnt + 1'b1; // R10
          end
        end
      end
      default: begin
        d = lpm_pkg::LPM_RESET;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      q <= lpm_pkg::LPM_RESET;
    end else begin
      q <= d;
    end
  end

  // every output but rtc_osc_en_out is a field of the registered state; that one is tied high
  assign core_clk_en_out = q.core_clk_en;
  assign main_osc_en_out = q.osc_en;
  assign irc_out_en_out = q.irc_out_en;
  assign irc_pwr_en_out = q.irc_pwr;
  assign rtc_osc_en_out = q.main_pwr | 1'b1; // R24
  assign pll_en_out = q.pll_en;
  assign pll_connect_out = q.pll_conn;
  assign cpu_core_clock_div_out = q.cpu_core_clock_div;
  assign usb_div_out = q.usb_div;
  assign flash_pwr_en_out = q.flash_pwr;
  assign flash_ready_out = q.flash_ok;
  assign pins_hold_out = q.pins_hold;
  assign retain_out = q.retain;
  assign main_pwr_en_out = q.main_pwr;
  assign mode_out = q.state;
  assign periph_clk_en_out = q.pclk_en;

  ////////////////////////////////////////////////////////////////////////
  a_light_core_only: assert property (@(posedge core_clk_in) disable iff (srst_in) // R1
    q.state == lpm_pkg::ST_SLEEP |-> !core_clk_en_out && irc_pwr_en_out && flash_pwr_en_out && $stable(pll_en_out))
    else $error("light sleep touched more than the core clock");
  a_deep_clocks_off: assert property (@(posedge core_clk_in) disable iff (srst_in) // R3
    q.state inside {lpm_pkg::ST_DSLEEP, lpm_pkg::ST_PDOWN}
      |-> !main_osc_en_out && !irc_out_en_out && pins_hold_out && retain_out && rtc_osc_en_out)
    else $error("clock or pin left active in deep mode");
  a_pll_auto_off: assert property (@(posedge core_clk_in) disable iff (srst_in) // R6
    q.state == lpm_pkg::ST_RUN && sleep_req_in && mode_sel_in == lpm_pkg::MODE_DEEP && !rtc_dpd_req_in
      |=> !pll_en_out && !pll_connect_out && cpu_core_clock_div_out == '0 && usb_div_out == '0)
    else $error("pll or divider not cleared on deep entry");
  a_deep_flash_on: assert property (@(posedge core_clk_in) disable iff (srst_in) // R8
    q.state == lpm_pkg::ST_DSLEEP |-> flash_pwr_en_out && irc_pwr_en_out)
    else $error("flash or rc power lost in deep sleep");
  a_pdown_power_off: assert property (@(posedge core_clk_in) disable iff (srst_in) // R12
    q.state == lpm_pkg::ST_PDOWN |-> !irc_pwr_en_out && !flash_pwr_en_out && !flash_ready_out)
    else $error("power-down left rc or flash powered");
  a_dpd_entry_src: assert property (@(posedge core_clk_in) disable iff (srst_in) // R17
    q.state != lpm_pkg::ST_DPD ##1 q.state == lpm_pkg::ST_DPD |-> $past(rtc_dpd_req_in) && !main_pwr_en_out)
    else $error("deep power-down entered without rtc request");
  a_dpd_exit_src: assert property (@(posedge core_clk_in) disable iff (srst_in) // R19
    q.state == lpm_pkg::ST_DPD ##1 q.state != lpm_pkg::ST_DPD |-> $past(rtc_alarm_in) || $past(reset_pin_in))
    else $error("deep power-down left without alarm or reset pin");
  a_flash_blocked: assert property (@(posedge core_clk_in) disable iff (srst_in) // R15
    q.flash_busy |-> !flash_ready_out)
    else $error("flash released while start-up timer runs");
  a_deep_irc_resume: assert property (@(posedge core_clk_in) disable iff (srst_in) // R9
    q.state == lpm_pkg::ST_OSC_WAIT && !q.src_main && !q.flash_busy && irc_tick_in && q.cnt == 16'h0003
      |=> core_clk_en_out && q.state == lpm_pkg::ST_RUN)
    else $error("rc wake did not resume after four cycles");
endmodule : low_power_mode_sequencer

// >>> src/wake_interrupt_latch.sv
// wake interrupt latch: holds the handed-over mask and flags a wake
`timescale 1ns/1ps
module wake_interrupt_latch (
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic capture_in,
  input wire logic [lpm_pkg::NIRQ-1:0] mask_in,
  input wire logic [lpm_pkg::NIRQ-1:0] irq_in,
  input wire logic clear_in,
  output logic wake_out
);
  lpm_pkg::wic_s q, d;

  ////////////////////////////////////////////////////////////////////////
  // next state: capture on entry, detect without any polling loop
  always_comb begin
    d = q;
    if (capture_in) begin
      d.mask = mask_in; // R20
      d.armed = 1'b1;
      d.pend = 1'b0;
    end
    if (clear_in) begin
      d.armed = 1'b0;
      d.pend = 1'b0;
    end
    // set wins over a clear in the same cycle so no interrupt is lost
    if (q.armed && |(q.mask & irq_in)) begin
      d.pend = 1'b1; // R21
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      q <= lpm_pkg::WIC_RESET;
    end else begin
      q <= d;
    end
  end

  assign wake_out = q.pend;

  ////////////////////////////////////////////////////////////////////////
  a_mask_capture: assert property (@(posedge core_clk_in) disable iff (srst_in) // R20
    capture_in && !clear_in |=> q.armed && q.mask == $past(mask_in))
    else $error("wake mask not captured at entry");
  a_wake_detect: assert property (@(posedge core_clk_in) disable iff (srst_in) // R21
    q.armed && |(q.mask & irq_in) |=> wake_out)
    else $error("masked interrupt did not raise wake");
endmodule : wake_interrupt_latch

// >>> testbench/core_side_model.sv
// core side model: interrupt controller mask, oscillator ticks and rtc requests
`timescale 1ns/1ps
module core_side_model (
  input wire logic clk_in,
  input wire logic [7:0] irc_period_in,
  input wire logic [31:0] irq_req_in,
  input wire logic [31:0] irq_en_in,
  input wire logic [31:0] prio_ok_in,
  input wire logic dpd_cmd_in,
  input wire logic alarm_load_in,
  input wire logic [15:0] alarm_delay_in,
  output logic irc_tick_out = 1'b0,
  output logic main_tick_out = 1'b0,
  output logic [31:0] irq_out,
  output logic [31:0] irq_mask_out,
  output logic rtc_dpd_req_out,
  output logic rtc_alarm_out = 1'b0
);
  logic [7:0] irc_cnt = 8'h00;
  logic [15:0] alarm_cnt = 16'h0000;
  ////////////////////////////////////////////////////////////
  // lines pass through; the handed-over mask keeps only enabled, urgent enough sources
  assign irq_out = irq_req_in;
  assign irq_mask_out = irq_en_in & prio_ok_in;
  // deep power-down is asked for by the rtc block alone
  assign rtc_dpd_req_out = dpd_cmd_in;
  ////////////////////////////////////////////////////////////
  // falling-edge updates keep the model off the sequencer's sampling edge
  always @(negedge clk_in) begin
    irc_cnt <= (irc_cnt + 8'h01 >= irc_period_in) ? 8'h00 : irc_cnt + 8'h01;
    irc_tick_out <= (irc_cnt == 8'h00);
    main_tick_out <= ~main_tick_out;
    // the always-on rtc keeps counting towards its alarm in every mode
    alarm_cnt <= alarm_load_in ? alarm_delay_in : alarm_cnt - {15'h0000, alarm_cnt != 16'h0000};
    rtc_alarm_out <= (alarm_cnt == 16'h0001);
  end
endmodule : core_side_model

// >>> testbench/low_power_mode_sequencer_tb.sv
// testbench for the low power mode sequencer: queued expectations checked by an output watcher
`timescale 1ns/1ps
module low_power_mode_sequencer_tb;
  localparam int unsigned START = 20;
  typedef struct {logic [2:0] m; logic r; logic [9:0] c; logic [9:0] k; int kind; int dur;} note_s;
  logic clk = 1'b0, srst = 1'b1, slp = 1'b0, dcmd = 1'b0, rpin = 1'b0, smain = 1'b0;
  logic pwr = 1'b0, pen = 1'b0, dwr = 1'b0, aload = 1'b0;
  logic [1:0] msel = 2'h0;
  logic [7:0] cdiv = 8'h00, iper = 8'h03;
  logic [3:0] udiv = 4'h0, pgate = 4'h0;
  logic [15:0] pdiv = 16'h0000;
  logic [31:0] ireq = 32'h00000000, ien = 32'h00000000, prio = 32'hFFFFFFFF, en_r;
  wire logic itick, mtick, dreq, alarm;
  wire logic [31:0] irq, imask;
  logic cke, osce, irco, ircp, rtco, plle, pllc, fpwr, frdy, hold, ret, mpwr;
  logic [7:0] cdo;
  logic [3:0] udo, pclk, last;
  logic [2:0] mode;
  logic [9:0] ctl;
  note_s notes[$];
  note_s cur;
  int failures = 0, checks = 0, ncyc, nirc, nmain;
  assign ctl = {cke, osce, irco, ircp, plle, pllc, fpwr, hold, ret, mpwr};
  ////////////////////////////////////////////////////////////
  core_side_model core_side_model_i (.clk_in(clk), .irc_period_in(iper), .irq_req_in(ireq), .irq_en_in(ien),
    .prio_ok_in(prio), .dpd_cmd_in(dcmd), .alarm_load_in(aload), .alarm_delay_in(16'h000A),
    .irc_tick_out(itick), .main_tick_out(mtick), .irq_out(irq), .irq_mask_out(imask),
    .rtc_dpd_req_out(dreq), .rtc_alarm_out(alarm));
  low_power_mode_sequencer #(.IRC_START_CYC(START)) low_power_mode_sequencer_i (.core_clk_in(clk),
    .srst_in(srst), .sleep_req_in(slp), .mode_sel_in(msel), .rtc_dpd_req_in(dreq), .rtc_alarm_in(alarm),
    .reset_pin_in(rpin), .clk_src_main_in(smain), .irc_tick_in(itick), .main_osc_tick_in(mtick),
    .irq_in(irq), .irq_mask_in(imask), .pll_wr_in(pwr), .pll_en_in(pen), .pll_conn_in(pen), .div_wr_in(dwr),
    .cpu_core_clock_div_in(cdiv), .usb_div_in(udiv), .periph_gate_in(pgate), .periph_div_in(pdiv),
    .core_clk_en_out(cke), .main_osc_en_out(osce), .irc_out_en_out(irco), .irc_pwr_en_out(ircp),
    .rtc_osc_en_out(rtco), .pll_en_out(plle), .pll_connect_out(pllc), .cpu_core_clock_div_out(cdo),
    .usb_div_out(udo), .flash_pwr_en_out(fpwr), .flash_ready_out(frdy), .pins_hold_out(hold),
    .retain_out(ret), .main_pwr_en_out(mpwr), .mode_out(mode), .periph_clk_en_out(pclk));
  ////////////////////////////////////////////////////////////
  task automatic fail(input string s);
    failures++;
    $display("ERROR at %0t: %s", $time, s);
  endtask : fail
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    checks++;
    if (got !== exp) begin
      fail(s);
    end
  endtask : chk
  task automatic report_and_stop();
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic note(input logic [2:0] m, input logic r, input logic [9:0] c, input logic [9:0] k,
                      input int kd, input int d);
    notes.push_back('{m, r, c, k, kd, d});
  endtask : note
  // power-down style wake: rc start-up, four rc ticks, then the flash timer runs out
  task automatic wake_notes();
    note(3'h5, 1'b0, 10'h048, 10'h048, 0, 0);
    note(3'h6, 1'b0, 10'h080, 10'h080, 1, START);
    note(3'h0, 1'b0, 10'h2C9, 10'h2FF, 2, 4);
    note(3'h0, 1'b1, 10'h2C9, 10'h2FF, 2, 396);
  endtask : wake_notes
  task automatic req(input logic [1:0] m, input logic d);
    @(negedge clk);
    msel <= m;
    slp <= 1'b1;
    dcmd <= d;
    @(negedge clk);
    slp <= 1'b0;
    dcmd <= 1'b0;
  endtask : req
  // pll and divider write; the pll connect follows the enable
  task automatic cfg(input logic e, input logic [7:0] c);
    @(negedge clk);
    pwr <= 1'b1;
    pen <= e;
    dwr <= 1'b1;
    cdiv <= c;
    udiv <= c[3:0];
    @(negedge clk);
    pwr <= 1'b0;
    dwr <= 1'b0;
    @(negedge clk);
  endtask : cfg
  // bounded wait for every queued state change to show up
  task automatic drain(input int lim);
    for (int i = 0; i < lim && notes.size() != 0; i++) @(negedge clk);
    if (notes.size() != 0) begin
      fail("expected state change missing");
      report_and_stop();
    end
    @(negedge clk);
  endtask : drain
  task automatic idle_check(input int n, input int left);
    repeat (n) @(negedge clk);
    chk(notes.size(), left, "state left too early");
  endtask : idle_check
  // window of 240 cycles is a whole number of periods for every divider picked
  task automatic periph();
    int d[4];
    int cnt[4];
    for (int i = 0; i < 4; i++) begin
      d[i] = $urandom_range(15, 0);
      while (240 % (d[i] + 1) != 0) d[i]--;
      cnt[i] = 0;
    end
    pgate <= 4'($urandom());
    pdiv <= {4'(d[3]), 4'(d[2]), 4'(d[1]), 4'(d[0])};
    repeat (40) @(negedge clk);
    repeat (240) begin
      @(negedge clk);
      for (int i = 0; i < 4; i++) cnt[i] += int'(pclk[i]);
    end
    for (int i = 0; i < 4; i++) chk(cnt[i], pgate[i] ? 240 / (d[i] + 1) : 0, "peripheral pulses");
  endtask : periph
  ////////////////////////////////////////////////////////////
  initial begin
    forever #2 clk = ~clk;
  end
  // watcher: each change of mode or flash ready takes the oldest note, counting cycles and ticks between
  always @(negedge clk) begin
    if (srst) begin
      last = {mode, frdy};
      ncyc = 0;
      nirc = 0;
      nmain = 0;
    end else begin
      ncyc++;
      nirc += int'(itick);
      nmain += int'(mtick);
      if ({mode, frdy} !== last) begin
        last = {mode, frdy};
        if (notes.size() == 0) begin
          fail("unexpected state change");
        end else begin
          cur = notes.pop_front();
          chk({mode, frdy}, {cur.m, cur.r}, "mode or flash ready");
          chk(ctl & cur.k, cur.c & cur.k, "clock and power controls");
          chk(rtco, 1'b1, "rtc oscillator stopped");
          if (cur.kind != 0) chk(cur.kind == 1 ? ncyc : cur.kind == 2 ? nirc : nmain, cur.dur, "wake delay");
        end
        ncyc = 0;
        nirc = 0;
        nmain = 0;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h129A));
    repeat (4) @(negedge clk);
    srst <= 1'b0;
    repeat (2) @(negedge clk);
    chk({mode, frdy, ctl, rtco, cdo, udo}, {3'h0, 1'b1, 10'h2C9, 1'b1, 12'h000}, "reset outputs");
    req(2'h3, 1'b0);
    idle_check(10, 0);
    // light sleep: unmasked line and an rtc request in sleep are ignored, peripherals keep going
    ien <= 32'h00000010;
    note(3'h1, 1'b1, 10'h0C9, 10'h3FF, 0, 0);
    note(3'h0, 1'b1, 10'h2C9, 10'h3FF, 0, 0);
    req(lpm_pkg::MODE_LIGHT, 1'b0);
    ireq <= 32'h00000001;
    dcmd <= 1'b1;
    @(negedge clk);
    dcmd <= 1'b0;
    periph();
    idle_check(1, 1);
    ireq <= 32'h00000010;
    drain(20);
    ireq <= 32'h00000000;
    periph();
    // deep sleep from the rc: pll and dividers cleared, captured mask alone decides the wake
    cfg(1'b1, 8'h3C);
    chk({plle, pllc, cdo, udo}, {2'h3, 8'h3C, 4'hC}, "pll and dividers written");
    en_r = $urandom() | 32'h00000003;
    ien <= en_r;
    prio <= 32'hFFFFFFFD;
    note(3'h2, 1'b1, 10'h04F, 10'h3FF, 0, 0);
    note(3'h6, 1'b1, 10'h080, 10'h080, 0, 0);
    note(3'h0, 1'b1, 10'h2C9, 10'h2FF, 2, 4);
    req(lpm_pkg::MODE_DEEP, 1'b0);
    chk({cdo, udo}, 12'h000, "dividers not cleared");
    cfg(1'b1, 8'h77);
    chk({plle, cdo}, 9'h000, "write taken while asleep");
    ien <= 32'hFFFFFFFF;
    prio <= 32'hFFFFFFFF;
    ireq <= ~en_r | 32'h00000002;
    idle_check(20, 2);
    ireq <= 32'h00000001;
    drain(100);
    ireq <= 32'h00000000;
    cfg(1'b1, 8'h22);
    chk({plle, pllc, cdo}, {2'h3, 8'h22}, "reprogramming after wake");
    // deep sleep from the main oscillator
    smain <= 1'b1;
    ien <= 32'h00000001;
    note(3'h2, 1'b1, 10'h04F, 10'h3FF, 0, 0);
    note(3'h6, 1'b1, 10'h100, 10'h100, 0, 0);
    note(3'h0, 1'b1, 10'h249, 10'h27F, 3, 4096);
    req(lpm_pkg::MODE_DEEP, 1'b0);
    ireq <= 32'h00000001;
    drain(10000);
    ireq <= 32'h00000000;
    smain <= 1'b0;
    // power-down with a slow rc oscillator
    iper <= 8'h05;
    note(3'h3, 1'b0, 10'h007, 10'h3FF, 0, 0);
    wake_notes();
    req(lpm_pkg::MODE_PDOWN, 1'b0);
    ireq <= 32'h00000001;
    drain(3000);
    ireq <= 32'h00000000;
    // deep power-down: the rtc request wins over a sleep request; left by alarm, then by reset pin
    for (int j = 0; j < 2; j++) begin
      note(3'h4, 1'b0, 10'h000, 10'h349, 0, 0);
      wake_notes();
      req(lpm_pkg::MODE_LIGHT, 1'b1);
      idle_check(20, 4);
      aload <= (j == 0);
      rpin <= (j == 1);
      @(negedge clk);
      aload <= 1'b0;
      rpin <= 1'b0;
      drain(3000);
    end
    report_and_stop();
  end
endmodule : low_power_mode_sequencer_tb
